// [hw/tcrr_top.v]
// result bank: apb slave, three shunt averagers, three bus result registers
`timescale 1ns/100ps
module tcrr_top (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output reg [31:0] prdata,
  output wire pslverr,
  input wire [2:0] shunt_valid,
  input wire [47:0] shunt_sample,
  input wire [2:0] bus_valid,
  input wire [47:0] bus_sample
);
`include "tcrr_regs.vh"
  // =============================================================
  // shunt channels, averaged
  reg [2:0] avg_sel_q;
  wire [47:0] shunt_res;
  wire [2:0] shunt_done;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_sh
      // 26 bits: 1024 full-scale 16-bit samples must not wrap the sum
      tcrr_avg #(.ACC_W(26)) u_avg (
        .pclk(pclk),
        .presetn(presetn),
        .avg_sel(avg_sel_q),
        .sample_valid(shunt_valid[g]),
        .sample(shunt_sample[g*16 +: 16]),
        .result_q(shunt_res[g*16 +: 16]),
        .done_q(shunt_done[g])
      );
    end
  endgenerate
  // =============================================================
  // bus channels: 8 mV per lsb code from the converter, whole-word load
  reg [15:0] bus_q [0:2];
  reg [2:0] bus_done_q;
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 3; i = i + 1) begin
        bus_q[i] <= `TCRR_RESULT_RST;
      end
      bus_done_q <= 3'h0;
    end else begin
      bus_done_q <= bus_valid;
      for (i = 0; i < 3; i = i + 1) begin
        if (bus_valid[i]) begin
          // low 3 bits forced zero; full scale 7FF8 = 32.76 V
          bus_q[i] <= {bus_sample[i*16 + 15], bus_sample[i*16 + 3 +: 12],
                       {`TCRR_RSVD_W{1'b0}}};
        end
      end
    end
  end
  // =============================================================
  // apb: zero wait states, unmapped reads zero with pslverr
  wire [3:0] idx = paddr[5:2];
  wire acc = psel && penable;
  reg mapped;
  reg [15:0] rd_word;
  always @* begin
    mapped = 1'b1;
    rd_word = 16'h0000;
    case (idx)
      `TCRR_IDX_CH1_SHUNT: rd_word = shunt_res[15:0];
      `TCRR_IDX_CH1_BUS: rd_word = bus_q[0];
      `TCRR_IDX_CH2_SHUNT: rd_word = shunt_res[31:16];
      `TCRR_IDX_CH2_BUS: rd_word = bus_q[1];
      `TCRR_IDX_CH3_SHUNT: rd_word = shunt_res[47:32];
      `TCRR_IDX_CH3_BUS: rd_word = bus_q[2];
      `TCRR_IDX_CTRL: rd_word = {13'h0000, avg_sel_q};
      `TCRR_IDX_STATUS: rd_word = {10'h000, bus_done_q, shunt_done};
      default: mapped = 1'b0;
    endcase
    if (paddr[1:0] != 2'h0 || paddr[7:6] != 2'h0) begin
      mapped = 1'b0;
    end
  end
  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || (pwrite && idx != `TCRR_IDX_CTRL));
  // =============================================================
  // read data captured in the setup cycle, so prdata leaves a flop
  // a result landing at the setup edge shows on the next read, never torn
  wire setup = psel && !penable;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite && mapped) begin
      prdata <= {16'h0000, rd_word};
    end else begin
      prdata <= 32'h00000000;
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg_sel_q <= `TCRR_AVG_RST;
    end else if (acc && pwrite && mapped && idx == `TCRR_IDX_CTRL) begin
      avg_sel_q <= pwdata[`TCRR_CTRL_AVG_HI:`TCRR_CTRL_AVG_LO];
    end
  end
endmodule // tcrr_top

// [hw/tcrr_regs.vh]
// register map, field layout and reset values of the result bank
`ifndef TCRR_REGS_VH
`define TCRR_REGS_VH
// =============================================================
// register indices (byte address = index * 4)
`define TCRR_IDX_CH1_SHUNT 4'h1
`define TCRR_IDX_CH1_BUS 4'h2
`define TCRR_IDX_CH2_SHUNT 4'h3
`define TCRR_IDX_CH2_BUS 4'h4
`define TCRR_IDX_CH3_SHUNT 4'h5
`define TCRR_IDX_CH3_BUS 4'h6
`define TCRR_IDX_CTRL 4'h8
`define TCRR_IDX_STATUS 4'h9
// =============================================================
// fields
`define TCRR_SIGN_BIT 15
`define TCRR_MAG_HI 14
`define TCRR_MAG_LO 3
`define TCRR_RSVD_W 3
`define TCRR_RESULT_RST 16'h0000
`define TCRR_FULL_POS 16'h7FF8
`define TCRR_FULL_NEG 16'h8000
`define TCRR_CTRL_AVG_HI 2
`define TCRR_CTRL_AVG_LO 0
`define TCRR_AVG_RST 3'h0
`endif

// [hw/tcrr_avg.v]
// one channel of shunt averaging with saturation to the 13-bit result code
`timescale 1ns/100ps
module tcrr_avg #(
  parameter ACC_W = 26
) (
  input wire pclk,
  input wire presetn,
  input wire [2:0] avg_sel,
  input wire sample_valid,
  input wire signed [15:0] sample,
  output reg [15:0] result_q,
  output reg done_q
);
`include "tcrr_regs.vh"
  // =============================================================
  // sample count and shift per select code
  reg [10:0] count_lim;
  reg [3:0] shift;
  always @* begin
    case (avg_sel)
      3'h0: begin count_lim = 11'h001; shift = 4'h0; end
      3'h1: begin count_lim = 11'h004; shift = 4'h2; end
      3'h2: begin count_lim = 11'h010; shift = 4'h4; end
      3'h3: begin count_lim = 11'h040; shift = 4'h6; end
      3'h4: begin count_lim = 11'h080; shift = 4'h7; end
      3'h5: begin count_lim = 11'h100; shift = 4'h8; end
      3'h6: begin count_lim = 11'h200; shift = 4'h9; end
      default: begin count_lim = 11'h400; shift = 4'hA; end
    endcase
  end
  // =============================================================
  // accumulate, then divide by shift and saturate
  reg signed [ACC_W-1:0] acc_q;
  reg [10:0] cnt_q;
  wire signed [ACC_W-1:0] acc_d = acc_q + {{(ACC_W-16){sample[15]}}, sample};
  wire signed [ACC_W-1:0] mean = acc_d >>> shift;
  wire last = (cnt_q + 11'h001) >= count_lim;
  reg [15:0] sat;
  always @* begin
    // mean is in raw 13-bit units; clamp before placing at 15..3
    if (mean > $signed({{(ACC_W-13){1'b0}}, 13'h0FFF})) begin
      sat = `TCRR_FULL_POS;
    end else if (mean < $signed({{(ACC_W-13){1'b1}}, 13'h1000})) begin
      sat = `TCRR_FULL_NEG;
    end else begin
      sat = {mean[12:0], {`TCRR_RSVD_W{1'b0}}};
    end
  end
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= {ACC_W{1'b0}};
      cnt_q <= 11'h000;
      result_q <= `TCRR_RESULT_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (sample_valid) begin
        if (last) begin
          result_q <= sat;
          done_q <= 1'b1;
          acc_q <= {ACC_W{1'b0}};
          cnt_q <= 11'h000;
        end else begin
          acc_q <= acc_d;
          cnt_q <= cnt_q + 11'h001;
        end
      end
    end
  end
endmodule // tcrr_avg

// [dv/tcrr_chk_sva.sv]
// assertions on the register port of the result bank
`timescale 1ns/100ps
module tcrr_chk (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  input wire [2:0] bus_valid,
  input wire [47:0] bus_sample
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====
  wire acc = psel && penable;
  wire hit = paddr[1:0] == 2'h0 && paddr >= 8'h04 && paddr <= 8'h18;
  sequence s_bus_ld;
    bus_valid[0] ##1 !bus_valid[0] ##1 acc && !pwrite && paddr == 8'h08;
  endsequence
  chk_always_ready: assert property (pready) else $error("pready low");
  chk_rsvd_zero: assert property (acc && hit |-> prdata[2:0] == 3'h0)
    else $error("reserved bits set");
  chk_upper_zero: assert property (acc |-> prdata[31:16] == 16'h0)
    else $error("upper half set");
  chk_write_refused: assert property (acc && pwrite && hit |-> pslverr)
    else $error("result write taken");
  chk_read_ok: assert property (acc && !pwrite && hit |-> !pslverr)
    else $error("result read refused");
  chk_unmapped_err: assert property (acc && paddr == 8'h00 |-> pslverr && prdata == 32'h0)
    else $error("unmapped answered");
  chk_idle_zero: assert property (!acc |-> prdata == 32'h0)
    else $error("data outside access");
  chk_bus_load: assert property (s_bus_ld |-> prdata[15:3] == $past(bus_sample[15:3], 2))
    else $error("bus result mismatch");
endmodule // tcrr_chk
bind tcrr_top tcrr_chk tcrr_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pready,
  .prdata, .pslverr, .bus_valid, .bus_sample);

// [dv/tcrr_host.sv]
// apb host model reading the result bank
`timescale 1ns/100ps
module tcrr_host (
  input wire pclk,
  input wire pready,
  input wire [31:0] prdata,
  input wire pslverr,
  output logic psel = 0,
  output logic penable = 0,
  output logic pwrite = 0,
  output logic [7:0] paddr = 0,
  output logic [31:0] pwdata = 0
);
  logic hung = 0;
  // ====
  // idle edge at the end, so psel is never driven twice in one step
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] d, output logic e);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    hung = pready !== 1'b1;
    d = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
endmodule // tcrr_host

// [dv/triple_channel_result_registers_tb_top.sv]
// self-checking bench for the result bank
`timescale 1ns/100ps
module triple_channel_result_registers_tb_top;
  logic pclk = 0;
  logic presetn = 0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [2:0] shunt_valid = 0, bus_valid = 0;
  logic [47:0] shunt_sample = 0, bus_sample = 0;
  int miscompares = 0, n_tests = 0;
  tcrr_top tcrr_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .prdata, .pslverr, .shunt_valid, .shunt_sample, .bus_valid, .bus_sample);
  tcrr_host tcrr_host_i (.pclk, .pready, .prdata, .pslverr, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  initial forever #5 pclk = ~pclk;
  // ====
  task automatic final_report;
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // bit 32 of exp is the error response
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] wd,
    input logic [32:0] exp);
    logic [31:0] d;
    logic e;
    tcrr_host_i.xfer(w, a, wd, d, e);
    n_tests++;
    if (tcrr_host_i.hung || {e, d} !== exp) begin
      $display("unexpected at %h exp %h got %h", a, exp, {e, d});
      miscompares++;
    end
    if (tcrr_host_i.hung) final_report;
  endtask
  task automatic smp(input logic b, input int c, input logic [15:0] v);
    if (b) begin
      bus_sample[16*c+:16] <= v;
      bus_valid[c] <= 1;
    end else begin
      shunt_sample[16*c+:16] <= v;
      shunt_valid[c] <= 1;
    end
    @(posedge pclk);
    bus_valid <= 0;
    shunt_valid <= 0;
  endtask
  task automatic t_reset;
    for (int a = 4; a <= 24; a += 4) acc(0, 8'(a), 0, 33'h0);
    $display("reset values done");
  endtask
  task automatic t_conv;
    logic [15:0] v [6] = '{16'h8007, 16'h7FFF, 16'h1234, 16'd2000, 16'hF830, 16'd5000};
    logic [15:0] x [6] = '{16'h8000, 16'h7FF8, 16'h1230, 16'h3E80, 16'hC180, 16'h7FF8};
    for (int c = 0; c < 6; c++) begin
      smp(c < 3, c % 3, v[c]);
      acc(0, 8'(c < 3 ? 8 + 8 * c : 8 * c - 20), 0, {17'h0, x[c]});
    end
    $display("conversion layout done");
  endtask
  task automatic t_avg;
    smp(0, 1, 16'h8000);
    acc(0, 8'h0C, 0, 33'h8000);
    acc(1, 8'h20, 32'h1, 33'h0);
    acc(0, 8'h20, 0, 33'h1);
    for (int i = 1; i <= 4; i++) begin
      smp(0, 0, 16'(10 * i));
      acc(0, 8'h04, 0, i < 4 ? 33'h3E80 : 33'hC8);
    end
    acc(1, 8'h20, 32'h2, 33'h0);
    for (int i = 0; i < 16; i++) begin
      smp(0, 2, -16'(8 * i));
      if (i == 14) acc(0, 8'h14, 0, 33'h7FF8);
      else @(posedge pclk);
    end
    acc(0, 8'h14, 0, 33'hFE20);
    $display("averaging done");
  endtask
  task automatic t_ro;
    acc(1, 8'h08, 32'hFFFF, 33'h100000000);
    acc(0, 8'h08, 0, 33'h8000);
    acc(0, 8'h00, 0, 33'h100000000);
    $display("read-only done");
  endtask
  task automatic t_status;
    smp(1, 1, 16'h0010);
    acc(0, 8'h24, 0, 33'h10);
    acc(0, 8'h24, 0, 33'h0);
    acc(0, 8'h10, 0, 33'h10);
    $display("status done");
  endtask
  task automatic t_mid_reset;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    acc(0, 8'h08, 0, 33'h0);
    acc(0, 8'h20, 0, 33'h0);
    $display("mid-run reset done");
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_conv;
    t_avg;
    t_status;
    t_ro;
    t_mid_reset;
    final_report;
  end
endmodule // triple_channel_result_registers_tb_top
